// [lcd_drive_pkg.sv]
`default_nettype none
package lcd_drive_pkg;

	// Panel geometry and serial expansion size
	localparam int COM_N      = 4;
	localparam int SEG_N      = 40;
	localparam int EXP_PINS   = 4;
	localparam int EXP_BITS   = 80;
	localparam int SEG_PORT_N = SEG_N - EXP_PINS;

	// Charge duty is measured in steps of 1/32 row
	localparam int ROW_STEPS  = 32;
	localparam int STEP_W     = 5;
	localparam logic [STEP_W-1:0] STEP_LAST  = 5'h1F;
	localparam logic [STEP_W-1:0] STEP_EIGHT = 5'h04;
	localparam logic [STEP_W-1:0] STEP_16TH  = 5'h02;
	localparam logic [STEP_W-1:0] STEP_32ND  = 5'h01;

	// Charge duty select codes
	localparam logic [3:0] CDS_ALWAYS_ON  = 4'h0;
	localparam logic [3:0] CDS_ALWAYS_OFF = 4'h7;
	localparam int         CDS_LONG_BIT   = 3;
	localparam int         CDS_32_BIT     = 2;

	// Frame clock select: bit 3 picks main clock, low bits the divider
	localparam int         FCS_MAIN_BIT  = 3;
	localparam int         PRE_W         = 11;
	localparam int         MAIN_DIV_BASE = 4;
	localparam logic [1:0] SUB_DIV1      = 2'h0;
	localparam logic [1:0] SUB_DIV2      = 2'h1;
	localparam logic [1:0] SUB_MASK1     = 2'h0;
	localparam logic [1:0] SUB_MASK2     = 2'h1;
	localparam logic [1:0] SUB_MASK4     = 2'h3;

	// Shifter bit index
	localparam int         IDX_W    = 7;
	localparam logic [IDX_W-1:0] IDX_LAST = 7'h4F;

	typedef enum logic [2:0] {
		PM_ACTIVE, PM_ACTIVE_MED, PM_SLEEP, PM_WATCH,
		PM_SUBACTIVE, PM_SUBSLEEP, PM_STANDBY
	} power_mode_type;

	typedef enum logic [1:0] {DUTY_STATIC, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_type;

	typedef enum logic [2:0] {LVL_V1, LVL_V2, LVL_V3, LVL_VSS, LVL_V23} level_type;

	typedef enum logic [1:0] {SH_IDLE, SH_SETUP, SH_CLOCK, SH_LATCH} shift_state_type;

	// Software controls
	typedef struct packed {
		logic           display_on;
		logic           drive_power_switch;
		logic [3:0]     charge_duty_select;
		logic [3:0]     frame_clock_select;
		duty_type       duty;
		logic           segment_expansion_select;
		logic [3:0]     segment_group_select;
		power_mode_type power_mode;
		logic           module_standby;
	} ctrl_type;

	// One row of display data: panel segments plus expander bits
	typedef struct packed {
		logic [EXP_BITS-1:0] exp_bits;
		logic [SEG_N-1:0]    seg_bits;
	} row_word_type;

	// Expansion pins, sharing one active-low output enable
	typedef struct packed {
		logic serial_data;
		logic expander_shift_strobe;
		logic expander_latch_strobe;
		logic alternation;
	} exp_pins_type;

endpackage
`default_nettype wire

// [lcd_drive_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

module lcd_drive_sequencer
	import lcd_drive_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   clk_en,
	// Subclock pin, sampled
	input  wire logic                   subclk,
	// Controls
	input  wire ctrl_type               ctrl,
	// Display data stream
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire row_word_type           in_data,
	// Bias divider and drive power
	output logic                        charge_on,
	output logic                        drive_power_on,
	// Panel levels
	output level_type [COM_N-1:0]       com_level,
	output level_type [SEG_N-1:0]       seg_level,
	output logic                        seg_port_mode,
	output logic                        display_active,
	// Expansion pins
	output exp_pins_type                exp_pins,
	output logic                        exp_oe_n
);

	// Whole block state: one copy is computed, one is registered
	typedef struct packed {
		logic                    sub_meta;
		logic                    sub_sync;
		logic                    sub_prev;
		logic [PRE_W-1:0]        pre;
		logic [1:0]              sub_div;
		logic [STEP_W-1:0]       step;
		logic [1:0]              row;
		logic                    alt;
		row_word_type            buf0;
		row_word_type            buf1;
		logic [1:0]              cnt;
		logic                    ready;
		row_word_type            cur;
		shift_state_type         sh_state;
		logic [IDX_W-1:0]        sh_idx;
		logic [EXP_BITS-1:0]     sh_word;
		exp_pins_type            pins;
		logic                    oe_n;
		logic                    charge;
		logic                    power_on;
		level_type [COM_N-1:0]   com;
		level_type [SEG_N-1:0]   seg;
		logic                    port_mode;
		logic                    active;
	} state_type;

	state_type st_r;
	state_type st_nxt;

	level_type [COM_N-1:0] com_w;
	level_type [SEG_N-1:0] seg_w;
	level_type [SEG_N-1:0] seg_out_w;

	logic       standby;
	logic       main_ok;
	logic       sub_ok;
	logic       run;
	logic       sub_edge;
	logic       tick;
	logic       row_end;
	logic       frame_end;
	logic       pop;
	logic       push;
	logic [1:0] last_row;
	logic [1:0] sub_mask;
	logic [PRE_W-1:0] pre_mask;

	// Common level for one pin
	// Selected commons swing V1/VSS, the others sit at the middle levels
	function automatic level_type com_lvl(input logic d, input logic m, input duty_type dy);
		level_type l;
		l = LVL_VSS;
		if (d) begin
			l = m ? LVL_VSS : LVL_V1;
		end else begin
			case (dy)
				DUTY_STATIC: l = m ? LVL_VSS : LVL_V1;
				DUTY_HALF:   l = LVL_V23;
				default:     l = m ? LVL_V2 : LVL_V3;
			endcase
		end
		return l;
	endfunction

	// Segment level for one pin
	// Segments swing against the common so lit pixels see the full bias
	function automatic level_type seg_lvl(input logic d, input logic m, input duty_type dy);
		level_type l;
		l = LVL_VSS;
		if (d) begin
			l = m ? LVL_V1 : LVL_VSS;
		end else begin
			case (dy)
				DUTY_STATIC: l = m ? LVL_VSS : LVL_V1;
				DUTY_HALF:   l = m ? LVL_VSS : LVL_V1;
				default:     l = m ? LVL_V3 : LVL_V2;
			endcase
		end
		return l;
	endfunction

	// Charge window within one row
	// 32 steps per row so n/8, 1/16 and 1/32 all land on whole steps
	function automatic logic charge_fn(input logic [3:0] cds, input logic [STEP_W-1:0] s);
		logic c;
		c = 1'b0;
		if (cds[CDS_LONG_BIT]) begin
			c = cds[CDS_32_BIT] ? (s < STEP_32ND) : (s < STEP_16TH);
		end else if (cds == CDS_ALWAYS_ON) begin
			c = 1'b1;
		end else if (cds == CDS_ALWAYS_OFF) begin
			c = 1'b0;
		end else begin
			c = s < STEP_EIGHT * {2'h0, cds[2:0]};
		end
		return c;
	endfunction

	// Level generation per pin
	genvar gi;
	generate
		for (gi = 0; gi < COM_N; gi++) begin : g_com
			logic d;
			// Static mode selects every common, else only the scanned row
			assign d = (ctrl.duty == DUTY_STATIC) || (st_r.row == 2'(gi));
			assign com_w[gi] = com_lvl(d, st_r.alt, ctrl.duty);
		end
		for (gi = 0; gi < SEG_N; gi++) begin : g_seg
			assign seg_w[gi] = seg_lvl(st_r.cur.seg_bits[gi], st_r.alt, ctrl.duty);
		end
		// Stopped panel and pins lent to the expander rest at VSS
		for (gi = 0; gi < SEG_N; gi++) begin : g_seg_out
			logic lent;
			assign lent = ctrl.segment_expansion_select && (gi >= SEG_PORT_N);
			assign seg_out_w[gi] = (run && !lent) ? seg_w[gi] : LVL_VSS;
		end
	endgenerate

	// Clock availability per power mode
	always_comb begin
		// Standby halts the subclock to this block though its oscillator runs
		standby = ctrl.power_mode == PM_STANDBY;
		main_ok = !ctrl.module_standby && (ctrl.power_mode == PM_ACTIVE ||
			ctrl.power_mode == PM_ACTIVE_MED || ctrl.power_mode == PM_SLEEP);
		sub_ok = !ctrl.module_standby && !standby;
		run = ctrl.display_on &&
			(ctrl.frame_clock_select[FCS_MAIN_BIT] ? main_ok : sub_ok);
		// Rising subclock edges, seen only after the synchroniser
		sub_edge = st_r.sub_sync && !st_r.sub_prev;
		// Subclock divided by 1, 2 or 4
		case (ctrl.frame_clock_select[1:0])
			SUB_DIV1: sub_mask = SUB_MASK1;
			SUB_DIV2: sub_mask = SUB_MASK2;
			default:  sub_mask = SUB_MASK4;
		endcase
		// Main prescaler period is 2^(4+n) clocks
		pre_mask = PRE_W'((1 << (MAIN_DIV_BASE + int'(ctrl.frame_clock_select[2:0]))) - 1);
		if (ctrl.frame_clock_select[FCS_MAIN_BIT]) begin
			tick = run && ((st_r.pre & pre_mask) == pre_mask);
		end else begin
			tick = run && sub_edge && ((st_r.sub_div & sub_mask) == sub_mask);
		end
	end

	// Row and frame boundaries, and buffer traffic
	always_comb begin
		// Frame ends after the last row of the chosen duty
		case (ctrl.duty)
			DUTY_STATIC: last_row = 2'h0;
			DUTY_HALF:   last_row = 2'h1;
			DUTY_THIRD:  last_row = 2'h2;
			default:     last_row = 2'h3;
		endcase
		row_end = tick && (st_r.step == STEP_LAST);
		frame_end = row_end && (st_r.row >= last_row);
		// Pop a word at each row end; an empty buffer repeats the row
		pop = row_end && (st_r.cnt != 2'h0);
		push = in_valid && st_r.ready;
	end

	// Next state
	always_comb begin
		st_nxt = st_r;
		// Subclock synchroniser
		st_nxt.sub_meta = subclk;
		st_nxt.sub_sync = st_r.sub_meta;
		st_nxt.sub_prev = st_r.sub_sync;
		// Prescaler and subclock divider run while their clock exists
		if (main_ok) begin
			st_nxt.pre = st_r.pre + PRE_W'(1);
		end
		if (sub_ok && sub_edge) begin
			st_nxt.sub_div = st_r.sub_div + 2'h1;
		end

		// Row step and frame sequencing
		if (!run) begin
			st_nxt.step = '0;
			st_nxt.row = 2'h0;
		end else if (tick) begin
			st_nxt.step = st_r.step + STEP_W'(1);
			if (row_end) begin
				st_nxt.row = frame_end ? 2'h0 : st_r.row + 2'h1;
			end
		end
		// Alternation flips once per frame and parks low while off
		if (!ctrl.display_on) begin
			st_nxt.alt = 1'b0;
		end else if (frame_end) begin
			st_nxt.alt = !st_r.alt;
		end

		// Two-entry buffer, pop at row end
		// in_ready falls only with both entries full, so a stall loses no word
		if (pop) begin
			st_nxt.cur = st_r.buf0;
			st_nxt.buf0 = st_r.buf1;
		end
		if (push) begin
			if ((st_r.cnt == 2'h0) || (st_r.cnt == 2'h1 && pop)) begin
				st_nxt.buf0 = in_data;
			end else begin
				st_nxt.buf1 = in_data;
			end
		end
		st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
		st_nxt.ready = st_nxt.cnt != 2'h2;

		// Bias divider charge window and power
		st_nxt.charge = run && charge_fn(ctrl.charge_duty_select, st_nxt.step);
		// Standby cuts drive power whatever the switch holds
		st_nxt.power_on = ctrl.drive_power_switch && !standby;
		st_nxt.active = run;

		// Panel levels, VSS while stopped so no DC reaches the panel
		st_nxt.com = '{default: LVL_VSS};
		if (run) begin
			st_nxt.com = com_w;
		end
		st_nxt.seg = seg_out_w;
		st_nxt.port_mode = ctrl.segment_expansion_select;

		// Serial expansion shifter
		// Two clocks per bit: data settles a clock before the strobe rises
		st_nxt.oe_n = !(ctrl.segment_expansion_select && !standby);
		st_nxt.pins.alternation = ctrl.display_on ? st_nxt.alt : 1'b0;
		st_nxt.pins.expander_latch_strobe = 1'b0;
		if (!ctrl.display_on) begin
			st_nxt.sh_state = SH_IDLE;
			st_nxt.pins.expander_shift_strobe = 1'b0;
		end else begin
			case (st_r.sh_state)
				SH_IDLE: begin
					if (pop && ctrl.segment_expansion_select) begin
						st_nxt.sh_word = st_r.buf0.exp_bits;
						st_nxt.sh_idx = '0;
						st_nxt.sh_state = SH_SETUP;
					end
				end
				SH_SETUP: begin
					st_nxt.pins.serial_data = st_r.sh_word[st_r.sh_idx];
					st_nxt.pins.expander_shift_strobe = 1'b0;
					st_nxt.sh_state = SH_CLOCK;
				end
				SH_CLOCK: begin
					st_nxt.pins.expander_shift_strobe = 1'b1;
					if (st_r.sh_idx == IDX_LAST) begin
						st_nxt.sh_state = SH_LATCH;
					end else begin
						st_nxt.sh_idx = st_r.sh_idx + IDX_W'(1);
						st_nxt.sh_state = SH_SETUP;
					end
				end
				// Latch pulse comes with the strobe fall after the last bit
				SH_LATCH: begin
					st_nxt.pins.expander_shift_strobe = 1'b0;
					st_nxt.pins.expander_latch_strobe = 1'b1;
					st_nxt.sh_state = SH_IDLE;
				end
				default: st_nxt.sh_state = SH_IDLE;
			endcase
		end
	end

	// State register
	// Reset wins over the clock enable so a frozen block can still be reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.com <= '{default: LVL_VSS};
			st_r.seg <= '{default: LVL_VSS};
			st_r.sh_state <= SH_IDLE;
			st_r.oe_n <= 1'b1;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign in_ready       = st_r.ready;
	assign charge_on      = st_r.charge;
	assign drive_power_on = st_r.power_on;
	assign com_level      = st_r.com;
	assign seg_level      = st_r.seg;
	assign seg_port_mode  = st_r.port_mode;
	assign display_active = st_r.active;
	assign exp_pins       = st_r.pins;
	assign exp_oe_n       = st_r.oe_n;

endmodule

`default_nettype wire

// [lcd_drive_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_checker
	import lcd_drive_pkg::*;
(
	// Clock, reset, controls
	input wire logic         clk,
	input wire logic         resetn,
	input wire logic         clk_en,
	input wire ctrl_type     ctrl,
	// Observed outputs
	input wire logic         charge_on,
	input wire logic         drive_power_on,
	input wire logic         seg_port_mode,
	input wire logic         display_active,
	input wire exp_pins_type exp_pins,
	input wire logic         exp_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Latch pulse follows the last shift strobe and lasts one clock
	sequence s_latch;
		$fell(exp_pins.expander_shift_strobe) ##1 !exp_pins.expander_latch_strobe;
	endsequence

	property p_pwr; clk_en && ctrl.power_mode == PM_STANDBY |=> !drive_power_on; endproperty
	property p_float; clk_en && ctrl.power_mode == PM_STANDBY |=> exp_oe_n; endproperty
	property p_off; clk_en && !ctrl.display_on |=> !display_active && !charge_on; endproperty
	property p_park;
		clk_en && !ctrl.display_on |=> !exp_pins.expander_shift_strobe
			&& !exp_pins.expander_latch_strobe && !exp_pins.alternation;
	endproperty
	property p_hold;
		clk_en && !ctrl.display_on && !$past(ctrl.display_on) |=> $stable(exp_pins.serial_data);
	endproperty
	property p_mstby; clk_en && ctrl.module_standby |=> !display_active; endproperty
	property p_sub;
		clk_en && ctrl.frame_clock_select[FCS_MAIN_BIT]
			&& ctrl.power_mode inside {PM_WATCH, PM_SUBACTIVE, PM_SUBSLEEP} |=> !display_active;
	endproperty
	property p_alt; $changed(exp_pins.alternation) |=> ($stable(exp_pins.alternation) || !display_active) [*8]; endproperty
	property p_latch; $rose(exp_pins.expander_latch_strobe) |-> s_latch; endproperty
	property p_never; clk_en && ctrl.charge_duty_select == CDS_ALWAYS_OFF |=> !charge_on; endproperty
	property p_port; clk_en |=> seg_port_mode == $past(ctrl.segment_expansion_select); endproperty

	a_pwr: assert property (p_pwr) else $error("drive power on in standby");
	a_float: assert property (p_float) else $error("expansion pins driven in standby");
	a_off: assert property (p_off) else $error("display runs while off");
	a_park: assert property (p_park) else $error("expansion pins not parked");
	a_hold: assert property (p_hold) else $error("serial data moved while off");
	a_mstby: assert property (p_mstby) else $error("display runs in module standby");
	a_sub: assert property (p_sub) else $error("display runs on stopped main clock");
	a_alt: assert property (p_alt) else $error("alternation toggles too often");
	a_latch: assert property (p_latch) else $error("latch pulse misplaced");
	a_never: assert property (p_never) else $error("charging while fixed off");
	a_port: assert property (p_port) else $error("port mode not following select");
endmodule
bind lcd_drive_sequencer lcd_drive_checker chk (.clk(clk), .resetn(resetn), .clk_en(clk_en),
	.ctrl(ctrl), .charge_on(charge_on), .drive_power_on(drive_power_on),
	.seg_port_mode(seg_port_mode), .display_active(display_active), .exp_pins(exp_pins),
	.exp_oe_n(exp_oe_n));
`default_nettype wire

// [lcd_expander_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_expander_model
	import lcd_drive_pkg::*;
(
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           resetn,
	// Expansion pins
	input  wire exp_pins_type   pins,
	input  wire logic           exp_oe_n,
	// Word shown by the expander
	output logic [EXP_BITS-1:0] latched
);
	logic [EXP_BITS-1:0] shift_r;
	logic                strobe_r;

	// Shift on rising strobe, first bit ends lowest; latch on pulse; ignore floating pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			shift_r <= '0;
			strobe_r <= 1'b0;
			latched <= '0;
		end else if (!exp_oe_n) begin
			strobe_r <= pins.expander_shift_strobe;
			if (pins.expander_shift_strobe && !strobe_r) begin
				shift_r <= {pins.serial_data, shift_r[EXP_BITS-1:1]};
			end
			if (pins.expander_latch_strobe) begin
				latched <= shift_r;
			end
		end
	end
endmodule
`default_nettype wire

// [lcd_drive_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_drive_sequencer_test;
	import lcd_drive_pkg::*;
	logic                  clk = 1'b0;
	logic                  resetn = 1'b0;
	logic                  clk_en = 1'b1;
	logic                  subclk = 1'b0;
	logic                  in_valid = 1'b0;
	ctrl_type              ctrl = '0;
	row_word_type          in_data = '0;
	row_word_type          word_b;
	logic                  in_ready;
	logic                  charge_on;
	logic                  drive_power_on;
	logic                  seg_port_mode;
	logic                  display_active;
	logic                  exp_oe_n;
	level_type [COM_N-1:0] com_level;
	level_type [SEG_N-1:0] seg_level;
	exp_pins_type          exp_pins;
	logic [EXP_BITS-1:0]   latched;
	int                    errors = 0;
	int                    checks_done = 0;
	int                    n;
	int                    codes [7] = '{0, 1, 3, 6, 7, 8, 12};
	int                    highs [7] = '{512, 64, 192, 384, 0, 32, 16};

	// Main clock and a subclock whose edges never meet a rising clk edge
	always #5 clk = ~clk;
	always #34 subclk = ~subclk;

	lcd_drive_sequencer dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .subclk(subclk),
		.ctrl(ctrl), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.charge_on(charge_on), .drive_power_on(drive_power_on), .com_level(com_level),
		.seg_level(seg_level), .seg_port_mode(seg_port_mode), .display_active(display_active),
		.exp_pins(exp_pins), .exp_oe_n(exp_oe_n));
	lcd_expander_model model (.clk(clk), .resetn(resetn), .pins(exp_pins),
		.exp_oe_n(exp_oe_n), .latched(latched));

	task automatic cmp(input string name, input logic [EXP_BITS-1:0] e, input logic [EXP_BITS-1:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %0h seen %0h", name, e, g);
		end
	endtask
	task automatic cmp_lvl(input string name, input level_type e, input level_type g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %0d seen %0d", name, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	// Offer one word and hold it until taken
	task automatic push(input row_word_type w);
		@(posedge clk);
		in_valid <= 1'b1;
		in_data <= w;
		@(posedge clk);
		while (in_ready !== 1'b1) @(posedge clk);
		in_valid <= 1'b0;
	endtask
	// Clocks until the alternation phase next changes
	task automatic next_toggle(output int c);
		logic m;
		m = exp_pins.alternation;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (exp_pins.alternation === m && c < 4000);
	endtask
	function automatic level_type seg_exp(input logic d, input logic m, input duty_type dt);
		if (d) return m ? LVL_V1 : LVL_VSS;
		if (dt inside {DUTY_STATIC, DUTY_HALF}) return m ? LVL_VSS : LVL_V1;
		return m ? LVL_V3 : LVL_V2;
	endfunction
	task automatic end_of_test;
		$display("Checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog, about twice the expected run
	initial begin
		#500000;
		errors++;
		end_of_test();
	end

	// Main sequence
	initial begin
		word_b = '0;
		word_b.seg_bits = 40'h55_5555_5555;
		word_b.exp_bits = 80'hC3A5_1234_5678_9ABC_DEF1;
		tick(6);
		cmp("reset_oe_n", 1'b1, exp_oe_n);
		cmp_lvl("reset_seg", LVL_VSS, seg_level[0]);
		resetn <= 1'b1;
		ctrl.frame_clock_select <= 4'h8;
		ctrl.drive_power_switch <= 1'b1;
		ctrl.segment_expansion_select <= 1'b1;
		ctrl.segment_group_select <= 4'h0;
		push(word_b);
		push(word_b);
		tick(3);
		cmp("in_ready_full", 1'b0, in_ready);
		cmp("off_active", 1'b0, display_active);
		ctrl.display_on <= 1'b1;
		tick(1300);
		cmp("in_ready_drained", 1'b1, in_ready);
		cmp("expander_word", word_b.exp_bits, latched);
		cmp_lvl("top_seg", LVL_VSS, seg_level[SEG_N-1]);
		cmp("power_on", 1'b1, drive_power_on);
		for (int d = 0; d < 4; d++) begin
			ctrl.duty <= duty_type'(d);
			next_toggle(n);
			next_toggle(n);
			cmp("frame_len", 512 * (d + 1), n);
			tick(100);
			cmp_lvl("seg_one", seg_exp(1'b1, exp_pins.alternation, duty_type'(d)), seg_level[0]);
			cmp_lvl("seg_zero", seg_exp(1'b0, exp_pins.alternation, duty_type'(d)), seg_level[1]);
			if (d == 0) cmp_lvl("com", exp_pins.alternation ? LVL_VSS : LVL_V1, com_level[3]);
			if (d == 1) cmp_lvl("com_idle", LVL_V23, com_level[3]);
			if (d == 2) begin
				cmp_lvl("com_idle", exp_pins.alternation ? LVL_V2 : LVL_V3, com_level[3]);
			end
		end
		ctrl.duty <= DUTY_STATIC;
		for (int i = 0; i < 7; i++) begin
			ctrl.charge_duty_select <= codes[i][3:0];
			tick(600);
			n = 0;
			repeat (512) begin
				@(posedge clk);
				if (charge_on === 1'b1) n++;
			end
			cmp("charge_high", highs[i], n);
		end
		ctrl.charge_duty_select <= CDS_ALWAYS_ON;
		ctrl.power_mode <= PM_WATCH;
		tick(5);
		cmp("watch_main", 1'b0, display_active);
		ctrl.frame_clock_select <= 4'h0;
		tick(200);
		cmp("watch_sub", 1'b1, display_active);
		cmp("watch_charge", 1'b1, charge_on);
		// Frame is 32 ticks of 2^k subclock periods of 68 ns, in tens of clocks
		for (int k = 1; k < 3; k++) begin
			ctrl.power_mode <= (k == 1) ? PM_SUBACTIVE : PM_SUBSLEEP;
			ctrl.frame_clock_select <= 4'(k);
			next_toggle(n);
			next_toggle(n);
			cmp("sub_frame", (2176 << k) / 100, n / 10);
		end
		ctrl.module_standby <= 1'b1;
		tick(5);
		cmp("mstby_active", 1'b0, display_active);
		ctrl.module_standby <= 1'b0;
		ctrl.power_mode <= PM_STANDBY;
		tick(5);
		cmp("stby_active", 1'b0, display_active);
		cmp("stby_power", 1'b0, drive_power_on);
		cmp("stby_oe_n", 1'b1, exp_oe_n);
		ctrl.power_mode <= PM_ACTIVE_MED;
		ctrl.frame_clock_select <= 4'h8;
		tick(5);
		cmp("act_oe_n", 1'b0, exp_oe_n);
		cmp("med_active", 1'b1, display_active);
		clk_en <= 1'b0;
		ctrl.display_on <= 1'b0;
		tick(5);
		cmp("frozen_active", 1'b1, display_active);
		clk_en <= 1'b1;
		tick(5);
		cmp("off_alt", 1'b0, exp_pins.alternation);
		cmp("off_strobe", 1'b0, exp_pins.expander_shift_strobe);
		cmp("off_run", 1'b0, display_active);
		end_of_test();
	end
endmodule
`default_nettype wire
